// ---- core/sep_eeprom_slave.sv ----
// What this block does
// - reset puts device in standby; any reset restarts it cleanly
// - sample data on clock rise, change output after fall, open-drain only
// - zero pulls data low, one releases it to the pull-up
// - start is data falling with clock high; nothing answered without start
// - data rising with clock high is stop and ends the command
// - address byte is 1010, three variant bits, then read/write bit
// - ninth clock: sender releases, receiver acks low or declines high
// - byte write: address, two memory address bytes, data, stop, all acked
// - stop after write starts programming; no drive, no ack meanwhile
// - extra data bytes accepted, up to 32 buffered from given address
// - page address fixed while loading; offset wraps inside page
// - after stop all loaded bytes commit in one programming cycle
// - every memory byte starts at erased value FFh
// - read address acked; byte at current address shifted out
// - selective read: dummy write of address, repeated start, read
// - acked read continues with next address, wrapping whole memory
// - pulses on clock and data no wider than noise width rejected
// - commands accepted only after the power-up delay
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_slave #(
  parameter logic [2:0] SEL_BITS = sep_pkg::SEL_ZERO,
  parameter int MEM_AW = sep_pkg::MEM_AW,
  parameter int PROG_CYC = sep_pkg::PROG_CYC,
  parameter int PU_CYC = sep_pkg::PU_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic prog_busy,
  output logic dev_ready
);
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int TW = $clog2(PROG_CYC + 1);
  localparam int UW = $clog2(PU_CYC + 1);
  localparam int PO = sep_pkg::PAGE_OW;
  localparam int FW = MEM_AW + sep_pkg::BYTE_W;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic scl_q;
    logic sda_q;
    sep_pkg::sep_mode_type mode;
    logic [3:0] bitcnt;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    logic [7:0] addr_hi;
    logic [MEM_AW-1:0] cur_addr;
    logic wr_pend;
    logic oe;
    logic busy;
    logic [TW-1:0] prog_tmr;
    logic ready;
    logic [UW-1:0] pu_tmr;
  } sep_state_type;

  sep_state_type s_ff;
  sep_state_type nxt_s;

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_match;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic [7:0] rd_byte;
  logic [MEM_AW-1:0] next_addr;

  sep_pin_filter u_scl_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(scl_in),
    .pin_out(scl_f)
  );

  sep_pin_filter u_sda_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(sda_in),
    .pin_out(sda_f)
  );

  // page buffer: written bytes queue here until the programming cycle
  sep_fifo #(
    .WIDTH(FW),
    .DEPTH(sep_pkg::FIFO_DEPTH)
  ) u_page_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({s_ff.cur_addr, s_ff.rx_sr}),
    .out_valid(fifo_out_valid),
    .out_ready(s_ff.busy),
    .out_data(fifo_out_data)
  );

  assign scl_rise = scl_f && !s_ff.scl_q;
  assign scl_fall = !scl_f && s_ff.scl_q;
  assign start_c = scl_f && s_ff.scl_q && s_ff.sda_q && !sda_f;
  assign stop_c = scl_f && s_ff.scl_q && !s_ff.sda_q && sda_f;
  assign addr_match = (s_ff.rx_sr[7:1] == {sep_pkg::DEV_TYPE, SEL_BITS});
  assign fifo_push = scl_fall && (s_ff.mode == sep_pkg::M_WDAT) && (s_ff.bitcnt == sep_pkg::BIT_LAST);
  assign rd_byte = s_ff.mem[s_ff.cur_addr];
  assign next_addr = s_ff.cur_addr + 1'b1;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.scl_q = scl_f;
    nxt_s.sda_q = sda_f;
    // power-up delay before the device answers
    if (!s_ff.ready) begin
      if (s_ff.pu_tmr == UW'(PU_CYC - 1)) begin
        nxt_s.ready = 1'b1;
      end else begin
        nxt_s.pu_tmr = s_ff.pu_tmr + 1'b1;
      end
    end
    // programming cycle: drain the page buffer, hold busy for the full time
    if (s_ff.busy) begin
      if (fifo_out_valid) begin
        nxt_s.mem[fifo_out_data[FW-1:sep_pkg::BYTE_W]] = fifo_out_data[7:0];
      end
      if (s_ff.prog_tmr != '0) begin
        nxt_s.prog_tmr = s_ff.prog_tmr - 1'b1;
      end else if (!fifo_out_valid) begin
        nxt_s.busy = 1'b0;
      end
    end
    // receive a bit on the rising edge; in read mode shift the send register, and sample the ack after the eighth bit
    if (scl_rise && (s_ff.mode != sep_pkg::M_IDLE)) begin
      if (s_ff.mode == sep_pkg::M_RDAT) begin
        if (s_ff.bitcnt < sep_pkg::BIT_LAST) begin
          nxt_s.tx_sr = {s_ff.tx_sr[6:0], 1'b0};
          nxt_s.bitcnt = s_ff.bitcnt + 1'b1;
        end else begin
          nxt_s.cur_addr = next_addr;
          if (!sda_f) begin
            nxt_s.tx_sr = s_ff.mem[next_addr];
            nxt_s.bitcnt = '0;
          end else begin
            nxt_s.mode = sep_pkg::M_IDLE;
          end
        end
      end else if (s_ff.bitcnt < sep_pkg::BIT_LAST) begin
        nxt_s.rx_sr = {s_ff.rx_sr[6:0], sda_f};
        nxt_s.bitcnt = s_ff.bitcnt + 1'b1;
      end
    end
    // change the output after the falling edge
    if (scl_fall && (s_ff.mode != sep_pkg::M_IDLE)) begin
      if (s_ff.mode == sep_pkg::M_RDAT) begin
        if (s_ff.bitcnt < sep_pkg::BIT_LAST) begin
          nxt_s.oe = !s_ff.tx_sr[7];
        end else begin
          nxt_s.oe = 1'b0;
        end
      end else if (s_ff.bitcnt == sep_pkg::BIT_LAST) begin
        nxt_s.bitcnt = sep_pkg::ACK_SLOT;
        nxt_s.oe = 1'b1;
        case (s_ff.mode)
          sep_pkg::M_DEV: begin
            if (!addr_match || !s_ff.ready || s_ff.busy) begin
              nxt_s.oe = 1'b0;
              nxt_s.mode = sep_pkg::M_IDLE;
            end
          end
          sep_pkg::M_ADH: begin
            nxt_s.addr_hi = s_ff.rx_sr;
          end
          sep_pkg::M_ADL: begin
            nxt_s.cur_addr = MEM_AW'({s_ff.addr_hi, s_ff.rx_sr});
          end
          sep_pkg::M_WDAT: begin
            if (fifo_in_ready) begin
              nxt_s.wr_pend = 1'b1;
              nxt_s.cur_addr[PO-1:0] = s_ff.cur_addr[PO-1:0] + 1'b1;
            end else begin
              nxt_s.oe = 1'b0;
              nxt_s.mode = sep_pkg::M_IDLE;
            end
          end
          default: begin
            nxt_s.oe = 1'b0;
          end
        endcase
      end else if (s_ff.bitcnt == sep_pkg::ACK_SLOT) begin
        nxt_s.oe = 1'b0;
        nxt_s.bitcnt = '0;
        case (s_ff.mode)
          sep_pkg::M_DEV: begin
            if (s_ff.rx_sr[0]) begin
              nxt_s.mode = sep_pkg::M_RDAT;
              nxt_s.tx_sr = rd_byte;
              nxt_s.oe = !rd_byte[7];
            end else begin
              nxt_s.mode = sep_pkg::M_ADH;
            end
          end
          sep_pkg::M_ADH: begin
            nxt_s.mode = sep_pkg::M_ADL;
          end
          sep_pkg::M_ADL: begin
            nxt_s.mode = sep_pkg::M_WDAT;
          end
          default: begin
            nxt_s.mode = s_ff.mode;
          end
        endcase
      end
    end
    // start and stop override any bit activity
    if (start_c) begin
      nxt_s.mode = sep_pkg::M_DEV;
      nxt_s.bitcnt = '0;
      nxt_s.oe = 1'b0;
    end else if (stop_c) begin
      nxt_s.mode = sep_pkg::M_IDLE;
      nxt_s.bitcnt = '0;
      nxt_s.oe = 1'b0;
      if (s_ff.wr_pend) begin
        nxt_s.wr_pend = 1'b0;
        nxt_s.busy = 1'b1;
        nxt_s.prog_tmr = TW'(PROG_CYC - 1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.mem <= {MEM_DEPTH{sep_pkg::ERASED}};
      s_ff.scl_q <= sep_pkg::IDLE_LEVEL;
      s_ff.sda_q <= sep_pkg::IDLE_LEVEL;
      s_ff.mode <= sep_pkg::M_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sda_out = sep_pkg::DRIVE_LOW;
  assign sda_oe = s_ff.oe;
  assign prog_busy = s_ff.busy;
  assign dev_ready = s_ff.ready;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_start_dev;
    start_c |=> (s_ff.mode == sep_pkg::M_DEV) && (s_ff.bitcnt == '0) && !s_ff.oe;
  endproperty
  a_start_dev: assert property (p_start_dev) else $error("start not taken");

  property p_stop_idle;
    stop_c |=> (s_ff.mode == sep_pkg::M_IDLE) && !s_ff.oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not ending command");

  property p_oe_after_fall;
    $rose(s_ff.oe) |-> $past(scl_fall);
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall) else $error("drive not after fall");

  property p_dev_ack_match;
    $rose(s_ff.oe) && ($past(s_ff.mode) == sep_pkg::M_DEV)
      |-> $past(s_ff.rx_sr[7:1]) == {sep_pkg::DEV_TYPE, SEL_BITS};
  endproperty
  a_dev_ack_match: assert property (p_dev_ack_match) else $error("ack on wrong address");

  property p_nomatch_idle;
    scl_fall && (s_ff.mode == sep_pkg::M_DEV) && (s_ff.bitcnt == sep_pkg::BIT_LAST) && !addr_match
      |=> (s_ff.mode == sep_pkg::M_IDLE) && !s_ff.oe;
  endproperty
  a_nomatch_idle: assert property (p_nomatch_idle) else $error("foreign address answered");

  property p_addr_ack;
    scl_fall && (s_ff.bitcnt == sep_pkg::BIT_LAST)
      && ((s_ff.mode == sep_pkg::M_ADH) || (s_ff.mode == sep_pkg::M_ADL))
      |=> s_ff.oe && (s_ff.bitcnt == sep_pkg::ACK_SLOT) ##1 s_ff.oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked");

  property p_busy_released;
    s_ff.busy |-> !s_ff.oe;
  endproperty
  a_busy_released: assert property (p_busy_released) else $error("drive during program");

  property p_stop_launch;
    stop_c && s_ff.wr_pend |=> s_ff.busy && !s_ff.wr_pend;
  endproperty
  a_stop_launch: assert property (p_stop_launch) else $error("stop did not program");

  property p_full_nack;
    fifo_push && !fifo_in_ready |=> (s_ff.mode == sep_pkg::M_IDLE) && !s_ff.oe;
  endproperty
  a_full_nack: assert property (p_full_nack) else $error("byte acked with full buffer");

  property p_page_wrap;
    fifo_push && fifo_in_ready && (&s_ff.cur_addr[PO-1:0])
      |=> (s_ff.cur_addr[PO-1:0] == '0) && $stable(s_ff.cur_addr[MEM_AW-1:PO]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page offset did not wrap");

  property p_read_wrap;
    scl_rise && (s_ff.mode == sep_pkg::M_RDAT) && (s_ff.bitcnt == sep_pkg::BIT_LAST)
      && (&s_ff.cur_addr) |=> (s_ff.cur_addr == '0);
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");

  property p_not_ready_quiet;
    !s_ff.ready |-> !s_ff.oe;
  endproperty
  a_not_ready_quiet: assert property (p_not_ready_quiet) else $error("answer before ready");

  property p_erased;
    $past(rst) |-> (s_ff.mem[0] == sep_pkg::ERASED) && (s_ff.mem[MEM_DEPTH-1] == sep_pkg::ERASED);
  endproperty
  a_erased: assert property (p_erased) else $error("memory not erased");

  c_read_next: cover property (scl_rise && (s_ff.mode == sep_pkg::M_RDAT)
    && (s_ff.bitcnt == sep_pkg::BIT_LAST) && !sda_f);
  c_program: cover property (stop_c && s_ff.wr_pend);
  c_poll_nack: cover property (scl_fall && (s_ff.mode == sep_pkg::M_DEV)
    && (s_ff.bitcnt == sep_pkg::BIT_LAST) && s_ff.busy);
  c_restart: cover property (start_c && (s_ff.mode == sep_pkg::M_WDAT));
endmodule
`default_nettype wire

// ---- core/sep_pkg.sv ----
package sep_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int FILTER_NS = 50;
  localparam int PROG_TIME_NS = 4000000;
  localparam int PU_TIME_NS = 350000;
  localparam int FILTER_CYC = (FILTER_NS / CLK_PERIOD_NS < 1) ? 1 : FILTER_NS / CLK_PERIOD_NS;
  localparam int PROG_CYC = (PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PU_CYC = (PU_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PU_TIME_NS / CLK_PERIOD_NS;
  localparam int MEM_AW = 12;
  localparam int PAGE_OW = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [2:0] SEL_ALT = 3'h4;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic DRIVE_LOW = 1'b0;
  typedef enum logic [2:0] {M_IDLE, M_DEV, M_ADH, M_ADL, M_WDAT, M_RDAT} sep_mode_type;
endpackage

// ---- core/sep_pin_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module sep_pin_filter #(
  parameter int FILT_CYC = sep_pkg::FILTER_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic pin_out
);
  localparam int CW = $clog2(FILT_CYC + 1) + 1;
  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic [CW-1:0] cnt;
  } sep_flt_type;
  sep_flt_type s_ff;
  sep_flt_type nxt_s;

  // two-flop synchroniser, then a level must hold past the noise width
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = pin_in;
    nxt_s.s2 = s_ff.s1;
    if (s_ff.s2 == s_ff.out) begin
      nxt_s.cnt = '0;
    end else if (s_ff.cnt == CW'(FILT_CYC)) begin
      nxt_s.out = s_ff.s2;
      nxt_s.cnt = '0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.s1 <= sep_pkg::IDLE_LEVEL;
      s_ff.s2 <= sep_pkg::IDLE_LEVEL;
      s_ff.out <= sep_pkg::IDLE_LEVEL;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_out = s_ff.out;

  property p_filter_stable;
    @(posedge ref_clk) disable iff (rst)
    $changed(s_ff.out) |-> ($past(s_ff.s2) == s_ff.out) && ($past(s_ff.s2, 2) == s_ff.out)
      && ($past(s_ff.s2, 3) == s_ff.out);
  endproperty
  a_filter_stable: assert property (p_filter_stable) else $error("short pulse passed filter");
endmodule
`default_nettype wire

// ---- core/sep_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = sep_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sep_fifo_type;
  sep_fifo_type s_ff;
  sep_fifo_type nxt_s;
  logic push;
  logic pop;

  assign in_ready = (s_ff.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = s_ff.mem[s_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sep_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module sep_i2c_master #(
  parameter int QTR_NS = 200
) (
  output logic scl,
  output logic m_oe,
  input wire logic sda
);
  initial begin
    scl = 1'h1;
    m_oe = 1'h0;
  end
  // start from idle, or repeated start from clock low
  task automatic bus_start();
    #(QTR_NS) m_oe = 1'h0;
    #(QTR_NS) scl = 1'h1;
    #(QTR_NS) m_oe = 1'h1;
    #(QTR_NS) scl = 1'h0;
  endtask
  // stop; clock then stands high
  task automatic bus_stop();
    #(QTR_NS) m_oe = 1'h1;
    #(QTR_NS) scl = 1'h1;
    #(QTR_NS) m_oe = 1'h0;
    #(QTR_NS);
  endtask
  // one clock: data moves mid-low, held through the high phase
  task automatic bit_io(input logic b, output logic s);
    #(QTR_NS) m_oe = ~b;
    #(QTR_NS) scl = 1'h1;
    #(QTR_NS) s = sda;
    #(QTR_NS) scl = 1'h0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'h1, nak);
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
  // data line held low with clock high, then a short high pulse
  task automatic glitch(input int w_ns);
    scl = 1'h0;
    #(QTR_NS) m_oe = 1'h1;
    #(QTR_NS) scl = 1'h1;
    #(QTR_NS) m_oe = 1'h0;
    #(w_ns) m_oe = 1'h1;
    #(QTR_NS) scl = 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_sep_eeprom_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sep_eeprom_slave;
  localparam int PU = 20;
  localparam int PROG = 600;
  localparam int LIMIT = 60000;
  localparam logic [7:0] AW = {sep_pkg::DEV_TYPE, sep_pkg::SEL_ZERO, 1'h0};
  localparam logic [7:0] AR = {sep_pkg::DEV_TYPE, sep_pkg::SEL_ZERO, 1'h1};
  localparam logic [7:0] FF = sep_pkg::ERASED;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic scl;
  logic m_oe;
  logic sda_out;
  logic sda_oe;
  logic prog_busy;
  logic dev_ready;
  wire sda;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  logic nak;
  logic [7:0] rd;

  // open-drain wire with pull-up
  assign sda = (m_oe | (sda_oe & ~sda_out)) ? 1'h0 : 1'h1;
  always #12.5 ref_clk = ~ref_clk;

  sep_eeprom_slave #(.PROG_CYC(PROG), .PU_CYC(PU)) dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .prog_busy(prog_busy), .dev_ready(dev_ready));
  sep_i2c_master mst (.scl(scl), .m_oe(m_oe), .sda(sda));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic exp_nak);
    mst.put_byte(d, nak);
    chk_bit(nak, exp_nak);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    #1 rst = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit(sda_oe, 1'h0);
    chk_bit(prog_busy, 1'h0);
    chk_bit(dev_ready, 1'h0);
    rst = 1'h0;
    repeat (PU - 2) @(posedge ref_clk);
    #1 chk_bit(dev_ready, 1'h0);
    repeat (4) @(posedge ref_clk);
    #1 chk_bit(dev_ready, 1'h1);
  endtask
  task automatic wr_addr(input logic [15:0] a);
    mst.bus_start();
    send(AW, 1'h0);
    send(a[15:8], 1'h0);
    send(a[7:0], 1'h0);
  endtask
  task automatic rd_from(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    wr_addr(a);
    mst.bus_start();
    send(AR, 1'h0);
    mst.get_byte(1'h1, rd);
    chk_byte(rd, e0);
    mst.get_byte(1'h0, rd);
    chk_byte(rd, e1);
    mst.bus_stop();
    chk_bit(sda_oe, 1'h0);
  endtask
  task automatic wait_prog();
    mst.bus_stop();
    #100 chk_bit(prog_busy, 1'h1);
    mst.bus_start();
    send(AW, 1'h1);
    for (int i = 0; i < 20 && nak; i++) begin
      mst.bus_stop();
      mst.bus_start();
      mst.put_byte(AW, nak);
    end
    chk_bit(nak, 1'h0);
    chk_bit(prog_busy, 1'h0);
    mst.bus_stop();
  endtask
  task automatic t_nomatch();
    mst.bus_start();
    send({sep_pkg::DEV_TYPE, sep_pkg::SEL_ALT, 1'h1}, 1'h1);
    send(AR, 1'h1);
    mst.bus_stop();
  endtask
  task automatic t_glitch();
    mst.glitch(25);
    send(AR, 1'h1);
    mst.bus_stop();
  endtask
  task automatic t_byte();
    wr_addr(16'h0005);
    send(8'h3C, 1'h0);
    wait_prog();
    rd_from(16'hF005, 8'h3C, FF);
  endtask
  task automatic t_page();
    wr_addr(16'h0FFF);
    send(8'hA5, 1'h0);
    send(8'h5A, 1'h0);
    send(8'hC3, 1'h0);
    wait_prog();
    rd_from(16'h0FFF, 8'hA5, FF);
    rd_from(16'hFFDF, FF, 8'h5A);
    mst.bus_start();
    send(AR, 1'h0);
    mst.get_byte(1'h0, rd);
    chk_byte(rd, 8'hC3);
    mst.bus_stop();
  endtask
  task automatic t_fill();
    wr_addr(16'h0100);
    for (int i = 0; i < 32; i++) begin
      send(8'h40 + 8'(i), 1'h0);
    end
    send(8'h99, 1'h1);
    wait_prog();
    rd_from(16'h011F, 8'h5F, FF);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    do_reset();
    rd_from(16'h0005, FF, FF);
    t_nomatch();
    t_glitch();
    t_byte();
    t_page();
    t_fill();
    do_reset();
    rd_from(16'h0005, FF, FF);
    close_out();
  end
endmodule
`default_nettype wire
